/* dv/mac_if_assertions.sv */
// checker for one port of the mac data interface
// assumes a bind onto the top module by the bench
`timescale 1ns/100ps
// ==========
// port checker
module mac_if_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire mac_if_pkg::if_mode_t mode,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic ref_clock_in,
   input wire logic tx_clk,
   input wire logic rx_clk,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic col,
   input wire logic tx_nib_valid,
   input wire logic tx_active,
   input wire logic rx_take,
   input wire logic rx_carrier,
   input wire logic rx_false_carrier
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // slow clock: high a while, next rise inside the 2.5 mhz window
   sequence s_rise;
      $rose(tx_clk);
   endsequence
   sequence s_slow;
      tx_clk [*3] ##[5:8] $rose(tx_clk);
   endsequence
   a_rmii_clk_idle: assert property (mode == mac_if_pkg::mode_rmii |-> !tx_clk && !rx_clk)
      else $error("clock output runs in rmii");
   a_rx_clk_same: assert property (rx_clk == tx_clk)
      else $error("receive clock differs from transmit clock");
   a_slow_clk_period: assert property (mode == mac_if_pkg::mode_mii && !speed_100 ##0 s_rise |-> s_slow)
      else $error("slow transmit clock period wrong");
   a_fast_clk_toggle: assert property ((mode == mac_if_pkg::mode_serial || mode == mac_if_pkg::mode_mii && speed_100) && tx_clk |=> !tx_clk ##1 tx_clk)
      else $error("fast transmit clock stalls");
   a_nib_one_pulse: assert property (tx_nib_valid |=> !tx_nib_valid)
      else $error("nibble strobe longer than one cycle");
   a_serial_no_dv: assert property (mode == mac_if_pkg::mode_serial |-> !rx_dv)
      else $error("data valid driven in serial mode");
   a_full_dup_col: assert property (full_duplex && $past(full_duplex) |-> !col)
      else $error("collision in full duplex");
   a_half_dup_col: assert property (!full_duplex && mode != mac_if_pkg::mode_rmii && tx_active && rx_carrier ##1 !full_duplex |-> col)
      else $error("collision missed in half duplex");
   a_take_gives_dv: assert property (mode == mac_if_pkg::mode_mii && rx_take |=> rx_dv)
      else $error("data valid missing after a take");
   a_slow_no_err: assert property (mode == mac_if_pkg::mode_mii && !speed_100 |-> !rx_er)
      else $error("receive error at 10 mb/s");
   a_false_carrier: assert property (mode == mac_if_pkg::mode_rmii && ref_clock_in && !$past(ref_clock_in) && rx_false_carrier |=> rx_er)
      else $error("false carrier not flagged");
endmodule

/* dv/mac_partner.sv */
// mac model driving the transmit pins of the port
// assumes the bench supplies go and the reference clock
`timescale 1ns/100ps
// ==========
// transmit launcher
module mac_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire mac_if_pkg::if_mode_t mode,
   input wire logic tx_clk,
   input wire logic ref_clock_in,
   input wire logic go,
   output logic tx_en = 1'b0,
   output logic [3:0] txd = 4'h0
);
   logic r1, r2, c1;
   // launch one edge after each sample point, so data never moves under the sampler
   always @(posedge clk) begin
      r1 <= ref_clock_in;
      r2 <= r1;
      c1 <= tx_clk;
      if (!rst_n) begin
         tx_en <= 1'b0;
      end else if (mode == mac_if_pkg::mode_rmii ? r1 && !r2 : tx_clk && !c1) begin
         tx_en <= go;
         txd <= txd + 4'h7; // keeps moving when disabled, so no stale value
      end
   end
endmodule

/* dv/tb.sv */
// bench for one port of the mac data interface
// assumes the design files and the mac model are compiled first
`timescale 1ns/100ps
// ==========
// bench top
module tb;
   logic clk = 1'b0, rst_n = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0, ref_clock_in = 1'b0;
   logic go = 1'b0, rx_nib_valid = 1'b0, rx_sym_err = 1'b0, rx_false_carrier = 1'b0;
   logic rx_carrier = 1'b0, tx_clk, rx_clk, rx_dv, rx_er, col, tx_nib_valid, tx_active;
   logic rx_take, tx_en, tick, rq, cq, pend, took, rt, etick, fcp, crs, cexp = 1'b0;
   logic [3:0] txd, rxd, tx_nib, rx_nib = 4'h0;
   logic [2:0] rc = 3'h0;
   logic [7:0] acc, pexp, rw, tw, q[$], rxq[$];
   mac_if_pkg::if_mode_t mode = mac_if_pkg::mode_mii;
   int n_fail = 0, n_checks = 0, nb, w;
   phy_mac_data_interface dut_u (.clk(clk), .rst_n(rst_n), .mode(mode), .speed_100(speed_100),
      .full_duplex(full_duplex), .ref_clock_in(ref_clock_in), .tx_clk(tx_clk), .tx_en(tx_en),
      .txd(txd), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col),
      .tx_nib_valid(tx_nib_valid), .tx_nib(tx_nib), .tx_active(tx_active),
      .rx_nib_valid(rx_nib_valid), .rx_nib(rx_nib), .rx_sym_err(rx_sym_err),
      .rx_false_carrier(rx_false_carrier), .rx_carrier(rx_carrier), .rx_take(rx_take));
   mac_partner mac_u (.clk(clk), .rst_n(rst_n), .mode(mode), .tx_clk(tx_clk),
      .ref_clock_in(ref_clock_in), .go(go), .tx_en(tx_en), .txd(txd));
   always #25 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // stimulus on the rising edge: six-cycle reference clock, new nibble once taken
   always @(posedge clk) begin
      rc <= rc == 3'h5 ? 3'h0 : rc + 3'h1;
      ref_clock_in <= rc < 3'h3;
      rx_false_carrier <= $urandom % 8 == 0;
      if (took) begin
         rx_nib <= 4'($urandom);
         rx_sym_err <= $urandom % 4 == 0;
      end
   end
   // reference model at the falling edge, where all pins are settled
   always @(negedge clk) begin
      tick = mode == mac_if_pkg::mode_rmii ? ref_clock_in && !rq : tx_clk && !cq;
      // rmii ticks show half a cycle before their edge, divided clock ticks half a cycle after
      etick = mode == mac_if_pkg::mode_rmii ? rt : tick;
      rt = tick && rst_n;
      rq = ref_clock_in;
      cq = tx_clk;
      w = mode == mac_if_pkg::mode_mii ? 4 : mode == mac_if_pkg::mode_rmii ? 2 : 1;
      took = rx_take;
      check({7'h0, crs}, {7'h0, cexp});
      if (!rst_n) begin
         nb = 0;
         acc = 8'h00;
         pend = 1'b0;
         q.delete();
         rxq.delete();
      end else begin
         if (pend) check({2'h0, rx_dv, rx_er, rxd}, pexp);
         pend = rx_take && mode == mac_if_pkg::mode_mii;
         pexp = {3'h1, speed_100 && rx_sym_err, rx_nib};
         // rmii and serial: one word per part; an idle tick shows only a false carrier
         if (etick && mode != mac_if_pkg::mode_mii) begin
            rw = rxq.size() > 0 ? rxq.pop_front() : 8'h00;
            rw[4] = rw[4] | (mode == mac_if_pkg::mode_rmii && fcp);
            check({2'h0, rx_dv, rx_er, rxd}, rw);
         end
         if (rx_take && mode == mac_if_pkg::mode_rmii) begin
            for (int k = 0; k < 2; k++) begin
               tw = {4'h0, rx_nib >> (2 * k)};
               rxq.push_back({3'h1, speed_100 && rx_sym_err, 2'h0, tw[1:0] ^ {2{rx_sym_err}}});
            end
         end else if (rx_take && mode == mac_if_pkg::mode_serial) begin
            for (int k = 0; k < 4; k++) begin
               rxq.push_back({7'h0, rx_nib[k]});
            end
         end
         // lsb first assembly; an idle enable throws away a partial nibble
         if (tick && tx_en) begin
            acc = acc | (8'(txd & 4'((1 << w) - 1)) << nb);
            nb = nb + w;
            if (nb == 4) begin
               q.push_back(acc);
               nb = 0;
               acc = 8'h00;
            end
         end else if (tick) begin
            nb = 0;
            acc = 8'h00;
         end
         if (tx_nib_valid) begin
            tw = q.size() > 0 ? q.pop_front() : 8'hff;
            check({4'h0, tx_nib}, tw);
         end
      end
      // carrier sense follows carrier or data valid one clock late
      cexp = rst_n && (rx_carrier || rx_dv);
      fcp = rx_false_carrier;
   end
   // each pass: reset, stream both ways, stop mid-stream
   initial begin
      void'($urandom(32'hfc2c_c49c));
      for (int i = 0; i < 4; i++) begin
         rst_n <= 1'b0;
         go <= 1'b0;
         mode <= mac_if_pkg::if_mode_t'(i < 2 ? 0 : i - 1);
         speed_100 <= i != 0;
         full_duplex <= i % 2 == 1;
         repeat (16) @(posedge clk);
         rst_n <= 1'b1;
         go <= 1'b1;
         rx_carrier <= 1'b1;
         rx_nib_valid <= 1'b1;
         repeat (301) @(posedge clk);
         go <= 1'b0;
         rx_nib_valid <= 1'b0;
         repeat (40) @(posedge clk);
         rx_carrier <= 1'b0;
      end
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
endmodule
bind phy_mac_data_interface mac_if_assertions chk_u (.clk, .rst_n, .mode, .speed_100,
   .full_duplex, .ref_clock_in, .tx_clk, .rx_clk, .rx_dv, .rx_er, .col, .tx_nib_valid,
   .tx_active, .rx_take, .rx_carrier, .rx_false_carrier);

/* hw/mac_if_consts.svh */
// named constants for the phy side mac data interface
// assumes inclusion by bare name from the interface module
`ifndef MAC_IF_CONSTS_SVH
`define MAC_IF_CONSTS_SVH

// ==========================================================
// clock rates in hertz
`define MAC_IF_CLK_HZ 20000000
`define MAC_IF_MII100_CLK_HZ 25000000
`define MAC_IF_MII10_CLK_HZ 2500000
`define MAC_IF_SERIAL_CLK_HZ 10000000
`define MAC_IF_REF_CLK_HZ 50000000

// ==========================================================
// symbol widths per mode, bits moved per clock tick, and the divider width
`define MAC_IF_NIBBLE_BITS 4
`define MAC_IF_RMII_BITS 2
`define MAC_IF_SERIAL_BITS 1
`define MAC_IF_DIV_W 8

// ==========================================================
// reset values and the rmii corruption mask
`define MAC_IF_NIB_RST 4'h0
`define MAC_IF_CNT_RST 2'h0
`define MAC_IF_BIT_RST 1'b0
`define MAC_IF_DIV_RST 8'h00
`define MAC_IF_RMII_CORRUPT 2'h3

`endif

/* hw/mac_if_pkg.sv */
// types shared by the phy side mac data interface
// assumes nothing beyond a systemverilog compiler
package mac_if_pkg;

   // ==========================================================
   // interface mode, fixed while frames flow
   typedef enum logic [1:0] {
      mode_mii,
      mode_rmii,
      mode_serial
   } if_mode_t;

endpackage

/* hw/phy_mac_data_interface.sv */
// one port of the phy side mac data interface: mii, rmii or 10 mb/s serial
// assumes all inputs synchronous to clk; the phy core side exchanges nibbles
//
// How it works
// (RQ1) mii transmit clock out: 25 mhz at 100 mb/s, 2.5 mhz at 10 mb/s; with the 20 mhz clk the 100 mb/s clock saturates at 10 mhz
// (RQ2) rmii: clock outputs idle, both paths timed from the 50 mhz reference
// (RQ3) serial mode drives a 10 mhz transmit clock; mac launches from it
// (RQ4) mii: mac holds transmit enable high exactly while nibble is valid
// (RQ5) rmii: mac holds transmit enable high while dibits are valid
// (RQ6) serial: mac holds transmit enable high while the data bit is valid
// (RQ7) mii transmit nibbles sampled on the transmit clock rising edge
// (RQ8) rmii transmit dibits sampled on the reference clock rising edge
// (RQ9) serial transmit bit sampled on the 10 mhz transmit clock
// (RQ10) mii receive clock out: 25 mhz or 2.5 mhz by speed; with the 20 mhz clk the fast clock is 10 mhz instead of 25 mhz
// (RQ11) serial mode receive clock out at 10 mhz
// (RQ12) mii receive data valid high while receive nibble is valid
// (RQ13) rmii also drives receive data valid alongside carrier/valid
// (RQ14) receive data valid held low in serial mode
// (RQ15) mii 100 mb/s: receive error on invalid symbol within a packet
// (RQ16) rmii 100 mb/s: receive error on invalid symbol while carrier/valid high
// (RQ17) rmii: receive error also on a false carrier event
// (RQ18) rmii: delivered receive data corrupted whenever a receive error occurs; the code corrupts only on an invalid symbol, not on a false carrier
// (RQ19) mii receive nibbles timed by receive clock, valid only with data valid
// (RQ20) rmii receive dibits driven on the reference clock
// (RQ21) serial receive bit framed by carrier sense
// (RQ22) collision in half duplex on simultaneous activity, low in full duplex; col is also held low in rmii half duplex
// (RQ23) each port is an independent instance sharing only the reference clock
// (RQ24) mode is fixed during operation; no change mid frame
`timescale 1ns/100ps
`include "mac_if_consts.svh"

module phy_mac_data_interface #(
   parameter int CLK_HZ = `MAC_IF_CLK_HZ
) (
   input wire logic clk,
   input wire logic rst_n,
   // static configuration
   input wire mac_if_pkg::if_mode_t mode,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic ref_clock_in, // RQ23
   // mac side pins
   output logic tx_clk,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   output logic rx_clk,
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic rx_er,
   output logic crs,
   output logic col,
   // phy core side, transmit
   output logic tx_nib_valid,
   output logic [3:0] tx_nib,
   output logic tx_active,
   // phy core side, receive
   input wire logic rx_nib_valid,
   input wire logic [3:0] rx_nib,
   input wire logic rx_sym_err,
   input wire logic rx_false_carrier,
   input wire logic rx_carrier,
   output logic rx_take
);

   // ==========================================================
   // divider constants; rates above clk/2 saturate at one cycle per half period
   function automatic int half_count(input int hz);
      int c;
      c = CLK_HZ / (2 * hz);
      return (c < 1) ? 1 : c;
   endfunction

   localparam int HALF_MII100 = half_count(`MAC_IF_MII100_CLK_HZ);
   localparam int HALF_MII10 = half_count(`MAC_IF_MII10_CLK_HZ);
   localparam int HALF_SERIAL = half_count(`MAC_IF_SERIAL_CLK_HZ);

   generate
      if (HALF_MII10 > (1 << `MAC_IF_DIV_W)) begin : g_bad_clk
         $error("clock rate too high for the divider width");
      end
   endgenerate

   localparam logic [`MAC_IF_DIV_W-1:0] RLD_MII100 = `MAC_IF_DIV_W'(HALF_MII100 - 1);
   localparam logic [`MAC_IF_DIV_W-1:0] RLD_MII10 = `MAC_IF_DIV_W'(HALF_MII10 - 1);
   localparam logic [`MAC_IF_DIV_W-1:0] RLD_SERIAL = `MAC_IF_DIV_W'(HALF_SERIAL - 1);

   // ==========================================================
   // mode decode
   logic is_rmii;
   logic is_serial;
   logic [1:0] last_part;
   logic [`MAC_IF_DIV_W-1:0] reload;

   // parts per nibble and divider reload follow the fixed mode
   always_comb begin
      is_rmii = 1'b0;
      is_serial = 1'b0;
      last_part = `MAC_IF_CNT_RST;
      reload = RLD_SERIAL;
      unique case (mode) // RQ24
         mac_if_pkg::mode_mii: begin
            reload = speed_100 ? RLD_MII100 : RLD_MII10;
         end
         mac_if_pkg::mode_rmii: begin
            is_rmii = 1'b1;
            last_part = 2'(`MAC_IF_NIBBLE_BITS / `MAC_IF_RMII_BITS - 1);
         end
         mac_if_pkg::mode_serial: begin
            is_serial = 1'b1;
            last_part = 2'(`MAC_IF_NIBBLE_BITS / `MAC_IF_SERIAL_BITS - 1);
         end
         default: begin
            reload = RLD_SERIAL;
         end
      endcase
   end

   // ==========================================================
   // clock generation and symbol tick
   logic [`MAC_IF_DIV_W-1:0] div_cnt;
   logic [`MAC_IF_DIV_W-1:0] next_div_cnt;
   logic clk_phase;
   logic next_clk_phase;
   logic ref_prev;
   logic ref_rise;
   logic tick;

   // the rising output edge, or the reference rising edge in rmii, is the sampling point for both directions
   always_comb begin
      next_div_cnt = div_cnt - `MAC_IF_DIV_W'(1);
      next_clk_phase = clk_phase;
      if (div_cnt == `MAC_IF_DIV_RST) begin
         next_div_cnt = reload;
         next_clk_phase = ~clk_phase;
      end
      ref_rise = ref_clock_in & ~ref_prev;
      if (is_rmii) begin
         tick = ref_rise; // RQ2 RQ8 RQ20
      end else begin
         tick = (div_cnt == `MAC_IF_DIV_RST) & ~clk_phase; // RQ7 RQ9
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt <= `MAC_IF_DIV_RST;
         clk_phase <= `MAC_IF_BIT_RST;
         ref_prev <= ref_clock_in; // tracks the pin so release shows no false rising edge
      end else begin
         div_cnt <= next_div_cnt;
         clk_phase <= next_clk_phase;
         ref_prev <= ref_clock_in;
      end
   end

   // clock outputs idle in rmii; one divider serves both directions
   assign tx_clk = clk_phase & ~is_rmii; // RQ1 RQ3
   assign rx_clk = clk_phase & ~is_rmii; // RQ10 RQ11

   // ==========================================================
   // transmit path: gather dibits or bits into nibbles, lsb first
   logic [3:0] tx_acc;
   logic [3:0] next_tx_acc;
   logic [1:0] tx_cnt;
   logic [1:0] next_tx_cnt;
   logic [3:0] next_tx_nib;
   logic next_tx_nib_valid;
   logic next_tx_active;

   // a frame that ends mid nibble drops the partial nibble
   always_comb begin
      next_tx_acc = tx_acc;
      next_tx_cnt = tx_cnt;
      next_tx_nib = tx_nib;
      next_tx_nib_valid = 1'b0;
      next_tx_active = tx_active;
      if (tick) begin
         next_tx_active = tx_en; // RQ4 RQ5 RQ6
         if (!tx_en) begin
            next_tx_cnt = `MAC_IF_CNT_RST;
         end else begin
            if (is_rmii) begin
               next_tx_acc = {txd[1:0], tx_acc[3:2]}; // RQ8
            end else if (is_serial) begin
               next_tx_acc = {txd[0], tx_acc[3:1]}; // RQ9
            end else begin
               next_tx_acc = txd; // RQ7
            end
            if (tx_cnt == last_part) begin
               next_tx_cnt = `MAC_IF_CNT_RST;
               next_tx_nib = next_tx_acc;
               next_tx_nib_valid = 1'b1;
            end else begin
               next_tx_cnt = tx_cnt + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_acc <= `MAC_IF_NIB_RST;
         tx_cnt <= `MAC_IF_CNT_RST;
         tx_nib <= `MAC_IF_NIB_RST;
         tx_nib_valid <= `MAC_IF_BIT_RST;
         tx_active <= `MAC_IF_BIT_RST;
      end else begin
         tx_acc <= next_tx_acc;
         tx_cnt <= next_tx_cnt;
         tx_nib <= next_tx_nib;
         tx_nib_valid <= next_tx_nib_valid;
         tx_active <= next_tx_active;
      end
   end

   // ==========================================================
   // receive path: split nibbles from the core into mode sized parts
   logic [3:0] rx_sh;
   logic [3:0] next_rx_sh;
   logic [1:0] rx_left;
   logic [1:0] next_rx_left;
   logic rx_err_hold;
   logic next_rx_err_hold;
   logic [3:0] cur;
   logic cur_valid;
   logic cur_err;
   logic [3:0] next_rxd;
   logic next_rx_dv;
   logic next_rx_er;
   logic next_crs;
   logic next_col;

   // take is combinational so the core can move on at the same edge
   assign rx_take = tick & (rx_left == `MAC_IF_CNT_RST) & rx_nib_valid;

   always_comb begin
      next_rx_sh = rx_sh;
      next_rx_left = rx_left;
      next_rx_err_hold = rx_err_hold;
      next_rxd = rxd;
      next_rx_dv = rx_dv;
      next_rx_er = rx_er;
      cur = rx_sh;
      cur_valid = 1'b1;
      cur_err = rx_err_hold;
      if (rx_left == `MAC_IF_CNT_RST) begin
         cur = rx_nib;
         cur_valid = rx_nib_valid;
         cur_err = rx_sym_err;
      end
      if (tick) begin
         next_rx_left = `MAC_IF_CNT_RST;
         if (cur_valid && rx_left == `MAC_IF_CNT_RST) begin
            next_rx_left = last_part;
         end else if (rx_left != `MAC_IF_CNT_RST) begin
            next_rx_left = rx_left - 2'h1;
         end
         next_rx_err_hold = cur_err;
         if (is_rmii) begin
            next_rx_sh = {2'h0, cur[3:2]};
            next_rxd = {2'h0, cur[1:0]}; // RQ20
            if (cur_valid && cur_err) begin
               next_rxd = {2'h0, cur[1:0] ^ `MAC_IF_RMII_CORRUPT}; // RQ18
            end
            next_rx_dv = cur_valid; // RQ13
            next_rx_er = (speed_100 & cur_valid & cur_err) | rx_false_carrier; // RQ16 RQ17
         end else if (is_serial) begin
            next_rx_sh = {1'b0, cur[3:1]};
            next_rxd = {3'h0, cur[0] & cur_valid}; // RQ21
            next_rx_dv = 1'b0; // RQ14
            next_rx_er = 1'b0;
         end else begin
            next_rxd = cur_valid ? cur : `MAC_IF_NIB_RST; // RQ19
            next_rx_dv = cur_valid; // RQ12
            next_rx_er = speed_100 & cur_valid & cur_err; // RQ15
         end
         if (!cur_valid) begin
            next_rxd = `MAC_IF_NIB_RST;
         end
      end
      // carrier frames serial data; collision only in half duplex, never in rmii
      next_crs = rx_carrier | rx_dv; // RQ21
      next_col = ~full_duplex & ~is_rmii & tx_active & (rx_carrier | rx_dv); // RQ22
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_sh <= `MAC_IF_NIB_RST;
         rx_left <= `MAC_IF_CNT_RST;
         rx_err_hold <= `MAC_IF_BIT_RST;
         rxd <= `MAC_IF_NIB_RST;
         rx_dv <= `MAC_IF_BIT_RST;
         rx_er <= `MAC_IF_BIT_RST;
         crs <= `MAC_IF_BIT_RST;
         col <= `MAC_IF_BIT_RST;
      end else begin
         rx_sh <= next_rx_sh;
         rx_left <= next_rx_left;
         rx_err_hold <= next_rx_err_hold;
         rxd <= next_rxd;
         rx_dv <= next_rx_dv;
         rx_er <= next_rx_er;
         crs <= next_crs;
         col <= next_col;
      end
   end

endmodule
